// >>> bench/remap_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module remap_checker
(
   input wire logic        ref_clk,                     // Clock.
   input wire logic        reset_n,                     // Reset, active low.
   input wire logic [7:0]  addr,                        // Address.
   input wire logic        rd,                          // Read strobe.
   input wire logic [31:0] rdata,                       // Read data.
   input wire logic        queued_invalidation_feature, // Queue present.
   input wire logic        in_region,                   // Inside region.
   input wire logic        region_active                // Region on.
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0) else $error("rdata not idle");
   a_limit_low_zero: assert property ($past(rd) && $past(addr) == 8'h78 |-> rdata[11:0] == 12'h000)
      else $error("limit low bits set");
   a_limit_top_zero: assert property ($past(rd) && $past(addr) == 8'h7C |-> rdata[31:16] == 16'h0000)
      else $error("limit top bits set");
   a_head_field_only: assert property ($past(rd) && $past(addr) == 8'h80 |-> rdata[3:0] == 4'h0 && rdata[31:19] == 13'h0000)
      else $error("head reserved bits set");
   a_head_upper_zero: assert property ($past(rd) && $past(addr) == 8'h84 |-> rdata == 32'h0)
      else $error("head upper word set");
   a_head_absent_zero: assert property ($past(rd) && $past(addr) == 8'h80 && !$past(queued_invalidation_feature) |-> rdata == 32'h0)
      else $error("head read without queue");
   a_region_needs_active: assert property (in_region |-> region_active) else $error("hit while region off");
   a_unmapped_read_zero: assert property ($past(rd) && $past(addr) == 8'h00 |-> rdata == 32'h0) else $error("unmapped read");
   cover property ($past(rd) && $past(addr) == 8'h80 && rdata != 32'h0);
   cover property (in_region);
   cover property ($fell(region_active));
endmodule // remap_checker
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic ref_clk = 0, reset_n = 0, wr = 0, rd = 0, flag = 1, feat = 1, done = 0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [63:0] dma = 64'h0;
   wire [31:0] rdata;
   wire in_region, region_active;
   int n_mismatch = 0, tests_run = 0;
   protected_high_range_and_inval_head i_protected_high_range_and_inval_head (.ref_clk(ref_clk),
      .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .high_region_supported_flag(flag), .queued_invalidation_feature(feat), .desc_done(done),
      .dma_addr(dma), .in_region(in_region), .region_active(region_active));
   initial forever #12.5 ref_clk = ~ref_clk;
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr_reg(logic [7:0] a, logic [31:0] d);
      @(posedge ref_clk) {wr, addr, wdata} <= {1'b1, a, d};
      @(posedge ref_clk) wr <= 1'b0;
   endtask
   task automatic rd_reg(logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk) {rd, addr} <= {1'b1, a};
      @(posedge ref_clk) rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic probe(logic [63:0] a, output logic hit);
      @(posedge ref_clk) dma <= a;
      repeat (2) @(posedge ref_clk);
      #1 hit = in_region;
   endtask
   task automatic pulses(int n);
      repeat (n)
      begin
         @(posedge ref_clk) done <= 1'b1;
         @(posedge ref_clk) done <= 1'b0;
      end
   endtask
   task automatic complete_run();
      $display("compares %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      logic [31:0] d;
      logic h;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd_reg(8'h78, d); check("limit reset", d, 32'h0);
      rd_reg(8'h80, d); check("head reset", d, 32'h0);
      rd_reg(8'h00, d); check("unmapped", d, 32'h0);
      wr_reg(8'h78, 32'hFFFFFFFF); wr_reg(8'h7C, 32'hFFFFFFFF);
      rd_reg(8'h78, d); check("limit lo ones", d, 32'hFFFFF000);
      rd_reg(8'h7C, d); check("limit hi ones", d, 32'h0000FFFF);
      $display("test limit alignment done");
      wr_reg(8'hA0, 32'h2000); wr_reg(8'hA4, 0); wr_reg(8'h78, 32'h2000); wr_reg(8'h7C, 0);
      wr_reg(8'hA8, 32'h20); // Protection goes on only after both bounds are set.
      probe(64'h2FFF, h); check("top of region", h, 1);
      probe(64'h3000, h); check("above region", h, 0);
      probe(64'h1FFF, h); check("below region", h, 0);
      wr_reg(8'hA8, 32'h0); wr_reg(8'h78, 32'h1000); wr_reg(8'hA8, 32'h20);
      probe(64'h2000, h); check("order off hit", h, 0);
      check("order off", region_active, 0);
      @(posedge ref_clk) flag <= 1'b0;
      wr_reg(8'h78, 32'hFFFFFFFF);
      rd_reg(8'h78, d); check("limit read only", d, 32'h1000);
      $display("test region done");
      wr_reg(8'hA8, 32'h10);
      rd_reg(8'hAC, d); check("status", d, 32'h1);
      pulses(3);
      rd_reg(8'h80, d); check("head 128", d, 32'h30);
      wr_reg(8'h80, 32'hFFFFFFFF);
      rd_reg(8'h80, d); check("head ro", d, 32'h30);
      wr_reg(8'hA8, 32'h0);
      rd_reg(8'h80, d); check("head cleared", d, 32'h0);
      wr_reg(8'hA8, 32'h11); pulses(1);
      rd_reg(8'h80, d); check("head 256", d, 32'h20);
      @(posedge ref_clk) feat <= 1'b0;
      rd_reg(8'h80, d); check("head absent", d, 32'h0);
      $display("test queue head done");
      complete_run();
   end
   initial
   begin
      #50000;
      n_mismatch++;
      complete_run();
   end
endmodule // tb_top
bind protected_high_range_and_inval_head remap_checker i_remap_checker (.ref_clk(ref_clk),
   .reset_n(reset_n), .addr(addr), .rd(rd), .rdata(rdata),
   .queued_invalidation_feature(queued_invalidation_feature), .in_region(in_region),
   .region_active(region_active));
`default_nettype wire

// >>> pkg/remap_consts.vh
// What this block does
// - Without high-region support the limit register is read-only; writes are ignored.
// - Limit alignment bits are not stored, read zero, decode as ones.
// - Equal base and limit above bit N protect 2^(N+1) bytes.
// - A limit below the base disables the protected high region.
// - Limit field holds the last address; bits at and above address width unimplemented.
// - Without queued invalidation the head register reads zero and ignores writes.
// - Head field bits 18:4 are read-only offset of next descriptor; others zero.
// - With 256-bit descriptors head bit 4 is always written zero.
// - Head resets to zero whenever queued invalidation is disabled.
// - Descriptor width select: 0 means 128-bit, 1 means 256-bit.
`ifndef REMAP_CONSTS_VH
`define REMAP_CONSTS_VH
`define ADDR_W              8
`define OFF_LIMIT_LO        8'h78
`define OFF_LIMIT_HI        8'h7C
`define OFF_HEAD_LO         8'h80
`define OFF_HEAD_HI         8'h84
`define OFF_BASE_LO         8'hA0
`define OFF_BASE_HI         8'hA4
`define OFF_CTRL            8'hA8
`define OFF_STATUS          8'hAC
`define HOST_ADDR_W         48
`define LIMIT_N             11
`define LIMIT_RESET         64'h0000000000000000
`define HEAD_LSB            4
`define HEAD_MSB            18
`define HEAD_RESET          15'h0000
`define DESC_W_128          1'b0
`define DESC_W_256          1'b1
`define QS_MSB              2
`define CTRL_WIDTH_BIT      0
`define CTRL_QS_LSB         1
`define CTRL_QIE_BIT        4
`define CTRL_PROT_BIT       5
`endif

// >>> src/head_counter.v
`timescale 1ns/100ps
`default_nettype none
`include "remap_consts.vh"
module head_counter
(
   input  wire        ref_clk,   // System clock.
   input  wire        reset_n,   // Asynchronous reset, active low.
   input  wire        enabled,   // Queued invalidation enabled status.
   input  wire        width_sel, // Descriptor width select.
   input  wire [2:0]  qs,        // Queue size exponent.
   input  wire        done,      // One descriptor processed.
   output reg  [14:0] head       // Head field, bits 18:4.
);
   // Entries count: 2^(qs+8) of 16 bytes, equal in bytes for either width.
   function [14:0] wrap_mask;
      input [2:0] size;
      begin
         wrap_mask = (15'h0100 << size) - 15'h0001;
      end
   endfunction
   reg [14:0] next_head;
   always @*
   begin
      next_head = head;
      if (done)
         next_head = (head + ((width_sel == `DESC_W_256) ? 15'h0002 : 15'h0001)) & wrap_mask(qs);
      if (width_sel == `DESC_W_256)
         next_head[0] = 1'b0;
   end
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         head <= `HEAD_RESET;
      else if (!enabled)
         head <= `HEAD_RESET;
      else
         head <= next_head;
   end
endmodule // head_counter
`default_nettype wire

// >>> src/limit_store.v
`timescale 1ns/100ps
`default_nettype none
`include "remap_consts.vh"
module limit_store
(
   input  wire        ref_clk,   // System clock.
   input  wire        reset_n,   // Asynchronous reset, active low.
   input  wire        supported, // High region implemented.
   input  wire        wr_lo,     // Write low word.
   input  wire        wr_hi,     // Write high word.
   input  wire [31:0] wdata,     // Write data.
   output reg  [63:0] value      // Stored value, alignment bits zero.
);
   localparam [63:0] KEEP = ((64'h1 << `HOST_ADDR_W) - 64'h1) & ~((64'h1 << (`LIMIT_N + 1)) - 64'h1);
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         value <= `LIMIT_RESET;
      else if (supported)
      begin
         // Only bits N+1 up to the address width hold storage.
         if (wr_lo)
            value[31:0] <= wdata & KEEP[31:0];
         if (wr_hi)
            value[63:32] <= wdata & KEEP[63:32];
      end
   end
endmodule // limit_store
`default_nettype wire

// >>> src/protected_high_range_and_inval_head.v
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "remap_consts.vh"
module protected_high_range_and_inval_head
(
   input  wire        ref_clk,        // System clock, 40 MHz.
   input  wire        reset_n,        // Asynchronous reset, active low.
   input  wire [7:0]  addr,           // Register byte address.
   input  wire [31:0] wdata,          // Write data.
   input  wire        wr,             // Write strobe.
   input  wire        rd,             // Read strobe.
   output reg  [31:0] rdata,          // Read data, cycle after rd.
   input  wire        high_region_supported_flag,  // Capability: high region present.
   input  wire        queued_invalidation_feature, // Capability: queue present.
   input  wire        desc_done,      // Pulse: one descriptor processed.
   input  wire [63:0] dma_addr,       // Address to check against region.
   output reg         in_region,      // Address falls inside the region.
   output reg         region_active   // Region enabled and not disabled by order.
);
   reg  [63:0] base;
   reg  [5:0]  ctrl;
   wire [63:0] limit;
   wire [14:0] head;
   wire        supported = high_region_supported_flag;
   wire        queue_on = queued_invalidation_feature & ctrl[`CTRL_QIE_BIT];
   // Software must keep the limit steady while protection is on; this is not enforced here.
   wire        prot_on = ctrl[`CTRL_PROT_BIT];
   limit_store u_limit
   (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .supported (supported),
      .wr_lo     (wr && addr == `OFF_LIMIT_LO),
      .wr_hi     (wr && addr == `OFF_LIMIT_HI),
      .wdata     (wdata),
      .value     (limit)
   );
   head_counter u_head
   (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .enabled   (queue_on),
      .width_sel (ctrl[`CTRL_WIDTH_BIT]),
      .qs      (ctrl[`CTRL_QS_LSB+2:`CTRL_QS_LSB]),
      .done    (desc_done),
      .head    (head)
   );
   localparam [63:0] LOW_ONES = (64'h1 << (`LIMIT_N + 1)) - 64'h1;
   wire [63:0] limit_dec = limit | LOW_ONES;
   wire        order_ok = !(limit < base);
   wire [63:0] head_word = {45'h0, head, 4'h0};
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         base <= 64'h0000000000000000;
         ctrl <= 6'h00;
      end
      else if (wr)
      begin
         // Head offsets are not in this case list: writes there fall away.
         case (addr)
            `OFF_BASE_LO: if (supported) base[31:0] <= wdata & ~LOW_ONES[31:0];
            `OFF_BASE_HI: if (supported) base[63:32] <= wdata;
            `OFF_CTRL:    ctrl <= wdata[5:0];
            default:      ctrl <= ctrl;
         endcase
      end
   end
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rdata <= 32'h00000000;
         in_region <= 1'b0;
         region_active <= 1'b0;
      end
      else
      begin
         region_active <= supported & prot_on & order_ok;
         // Equal upper bits give one aligned block of 2^(N+1) bytes.
         in_region <= supported & prot_on & order_ok &
                      (dma_addr >= base) & (dma_addr <= limit_dec);
         rdata <= 32'h00000000;
         if (rd)
         begin
            case (addr)
               `OFF_LIMIT_LO: rdata <= limit[31:0];
               `OFF_LIMIT_HI: rdata <= limit[63:32];
               `OFF_HEAD_LO:  rdata <= queued_invalidation_feature ? head_word[31:0] : 32'h0;
               `OFF_HEAD_HI:  rdata <= 32'h00000000;
               `OFF_BASE_LO:  rdata <= base[31:0];
               `OFF_BASE_HI:  rdata <= base[63:32];
               `OFF_CTRL:     rdata <= {26'h0, ctrl};
               `OFF_STATUS:   rdata <= {30'h0, order_ok, queue_on};
               default:       rdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // protected_high_range_and_inval_head
`default_nettype wire
